// ==== rtl/rsl_cfg.svh ====
// Strap latch constants: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the strap latch design files.
`ifndef RSL_CFG_SVH
`define RSL_CFG_SVH

// ==========================================================================
// Register byte offsets (low address byte, word aligned)
`define RSL_OFS_STATUS 8'h00
`define RSL_OFS_LEDPOL 8'h04
`define RSL_OFS_CTRL 8'h08
`define RSL_OFS_PORTADDR 8'h0c

// ==========================================================================
// Field positions
`define RSL_ST_BASE_LSB 0
`define RSL_ST_MODE_LSB 8
`define RSL_ST_BCAST_BIT 16
`define RSL_ST_STYLE_BIT 17
`define RSL_ST_TEST_BIT 30
`define RSL_ST_CAP_BIT 31
`define RSL_CTL_BCAST_BIT 0
`define RSL_CTL_ACT_LSB 8
`define RSL_PA_STRIDE 8

// ==========================================================================
// Reset values and fixed addresses
`define RSL_RST_BASE 5'h00
`define RSL_RST_MODE 5'h00
`define RSL_RST_POL 8'h00
`define RSL_RST_ACT 8'h00
`define RSL_RST_WORD 32'h0000_0000
`define RSL_BCAST_ADDR 5'h00

`endif

// ==== rtl/rsl_pkg.sv ====
// Types shared by the strap latch design.
// Assumes rsl_cfg.svh holds all numeric constants.
package rsl_pkg;

  // ========================================================================
  // Capture progress and LED style
  typedef enum logic {CAP_WAIT, CAP_DONE} rsl_cap_t;
  typedef enum logic {LED_TRICOLOR, LED_INDIVIDUAL} rsl_led_style_t;

endpackage

// ==== rtl/rsl_strap_latch.sv ====
// Reset strap latch: captures board straps when chip reset is released.
// Assumes straps and pins synchronous to clk_sys, one AHB-Lite master.
`timescale 1ns/100ps
`default_nettype none
`include "rsl_cfg.svh"

module rsl_strap_latch
  import rsl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Strap pins
  input wire logic [4:0] mgmtBaseAddrStrap,
  input wire logic [4:0] modeSelStrap,
  input wire logic broadcastDefaultStrap,
  input wire logic ledStyleStrap,
  input wire logic testSelect,
  // LED pins shared with polarity straps
  input wire logic [7:0] ledPinIn,
  output logic [7:0] ledPinOut,
  output logic [7:0] ledPinOe,
  // Management address match
  input wire logic [4:0] mgmtAddr,
  output logic [3:0] portHit,
  output logic broadcastHit,
  // Configuration to the ports
  output logic [19:0] portAddr,
  output logic [4:0] deviceMode,
  output logic ledStyle,
  output logic [7:0] ledOutputPolarity,
  output logic testState,
  output logic strapsValid,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ========================================================================
  // Helpers
  function automatic logic [4:0] rslPortAddr(input logic [4:0] base, input logic [1:0] idx);
    rslPortAddr = base + {3'h0, idx};
  endfunction

  // ========================================================================
  // Strap capture
  rsl_cap_t capFf;
  logic [4:0] baseFf;
  logic [4:0] modeFf;
  logic bcastStrapFf;
  rsl_led_style_t styleFf;
  logic [7:0] polFf;
  logic broadcastEnFf;
  logic [7:0] ledActiveFf;
  logic nxt_broadcastEn;
  logic [7:0] nxt_ledActive;

  wire capNow = (capFf == CAP_WAIT);
  wire captured = (capFf == CAP_DONE);

  // Capture in the first edge after release; LEDs stay undriven until then
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      capFf <= CAP_WAIT;
      baseFf <= `RSL_RST_BASE;
      modeFf <= `RSL_RST_MODE;
      bcastStrapFf <= 1'b0;
      styleFf <= LED_TRICOLOR;
      polFf <= `RSL_RST_POL;
    end else if (capNow) begin
      capFf <= CAP_DONE;
      baseFf <= mgmtBaseAddrStrap;
      modeFf <= modeSelStrap;
      bcastStrapFf <= broadcastDefaultStrap;
      styleFf <= ledStyleStrap ? LED_INDIVIDUAL : LED_TRICOLOR;
      polFf <= ~ledPinIn;
    end
  end
  // No else branch: values hold whatever the pins do later

  // ========================================================================
  // Outputs to the ports
  genvar g;
  for (g = 0; g < 4; g++) begin : gPort
    assign portAddr[g*5 +: 5] = rslPortAddr(baseFf, 2'(g));
    // Base above 0x1C would wrap the upper ports
    assign portHit[g] = captured && (mgmtAddr == rslPortAddr(baseFf, 2'(g)));
  end
  assign broadcastHit = captured && broadcastEnFf && (mgmtAddr == `RSL_BCAST_ADDR);
  assign deviceMode = modeFf;
  assign ledStyle = styleFf;
  assign ledOutputPolarity = polFf;
  assign strapsValid = captured;
  // Test state shuts the LED drivers and shows in status bit 30; nothing else depends on it
  assign testState = testSelect;
  assign ledPinOe = (captured && !testSelect) ? 8'hff : 8'h00;
  // Polarity one drives the active level as is, zero drives it inverted
  assign ledPinOut = polFf ~^ ledActiveFf;

  // ========================================================================
  // AHB-Lite slave: writes take one wait state so a following read is fresh
  logic wrPendFf;
  logic wrDoneFf;
  logic [7:0] wrAddrFf;
  logic [31:0] hrdataFf;

  wire accept = hsel && htrans[1] && hready;
  wire wrAccept = accept && hwrite;
  wire rdAccept = accept && !hwrite;
  wire wrCommit = wrPendFf && !wrDoneFf;
  wire ctrlWrite = wrCommit && (wrAddrFf == `RSL_OFS_CTRL);

  wire [31:0] statusWord = ({27'h0, baseFf} << `RSL_ST_BASE_LSB)
    | ({27'h0, modeFf} << `RSL_ST_MODE_LSB)
    | ({31'h0, bcastStrapFf} << `RSL_ST_BCAST_BIT)
    | ({31'h0, styleFf == LED_INDIVIDUAL} << `RSL_ST_STYLE_BIT)
    | ({31'h0, testSelect} << `RSL_ST_TEST_BIT)
    | ({31'h0, captured} << `RSL_ST_CAP_BIT);
  wire [31:0] polWord = {24'h0, polFf};
  wire [31:0] ctrlWord = ({31'h0, broadcastEnFf} << `RSL_CTL_BCAST_BIT)
    | ({24'h0, ledActiveFf} << `RSL_CTL_ACT_LSB);
  wire [31:0] paWord = {3'h0, portAddr[19:15], 3'h0, portAddr[14:10],
    3'h0, portAddr[9:5], 3'h0, portAddr[4:0]};
  wire [7:0] rdOfs = haddr[7:0];
  wire [31:0] rdWord = (rdOfs == `RSL_OFS_STATUS) ? statusWord :
    (rdOfs == `RSL_OFS_LEDPOL) ? polWord :
    (rdOfs == `RSL_OFS_CTRL) ? ctrlWord :
    (rdOfs == `RSL_OFS_PORTADDR) ? paWord : `RSL_RST_WORD;

  // Capture loads the broadcast default once; software may override later
  assign nxt_broadcastEn = capNow ? !broadcastDefaultStrap :
    ctrlWrite ? hwdata[`RSL_CTL_BCAST_BIT] : broadcastEnFf;
  assign nxt_ledActive = ctrlWrite ? hwdata[`RSL_CTL_ACT_LSB +: 8] : ledActiveFf;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      broadcastEnFf <= 1'b0;
      ledActiveFf <= `RSL_RST_ACT;
    end else begin
      broadcastEnFf <= nxt_broadcastEn;
      ledActiveFf <= nxt_ledActive;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPendFf <= 1'b0;
      wrDoneFf <= 1'b0;
      wrAddrFf <= `RSL_OFS_STATUS;
    end else if (wrCommit) begin
      wrDoneFf <= 1'b1;
    end else begin
      wrPendFf <= wrAccept;
      wrDoneFf <= 1'b0;
      wrAddrFf <= wrAccept ? haddr[7:0] : wrAddrFf;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hrdataFf <= `RSL_RST_WORD;
    end else if (rdAccept) begin
      hrdataFf <= rdWord;
    end
  end

  assign hrdata = hrdataFf;
  assign hreadyout = !wrCommit;
  assign hresp = 1'b0;

  // ========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_base_capture: assert property (
    (capNow ##1 captured) |-> baseFf == $past(mgmtBaseAddrStrap))
    else $error("base address not captured at reset release");
  chk_base_bit_level: assert property (
    (capNow && mgmtBaseAddrStrap[0]) |=> baseFf[0])
    else $error("high base strap bit not read as one");
  chk_port_offset: assert property (
    (captured && baseFf <= 5'h1c && mgmtAddr == baseFf + 5'h02) |-> portHit == 4'b0100)
    else $error("port two not matched at base plus two");
  chk_pol_low_pin: assert property (
    (capNow && !ledPinIn[3]) |=> polFf[3] && ledPinOut[3] == ledActiveFf[3])
    else $error("low LED strap did not give active high");
  chk_pol_high_pin: assert property (
    (capNow ##1 captured) |-> polFf == ~$past(ledPinIn))
    else $error("LED polarity not inverse of strap");
  chk_mode_capture: assert property (
    (capNow ##1 captured) |-> deviceMode == $past(modeSelStrap))
    else $error("device mode not captured");
  chk_bcast_default: assert property (
    capNow |=> broadcastEnFf == !$past(broadcastDefaultStrap) && !$past(ctrlWrite))
    else $error("broadcast default wrong after capture");
  chk_style_capture: assert property (
    (capNow ##1 captured) |-> ledStyle == $past(ledStyleStrap))
    else $error("LED style not captured");
  chk_capture_once: assert property (
    capNow |=> captured ##1 captured)
    else $error("capture not done at first edge after release");
  chk_straps_hold: assert property (
    (captured && $past(captured)) |-> $stable(baseFf) && $stable(modeFf) && $stable(polFf)
      && $stable(styleFf) && $stable(bcastStrapFf))
    else $error("latched strap changed after capture");

endmodule // rsl_strap_latch

`default_nettype wire

// ==== sim/rsl_strap_board.sv ====
// Board model: strap pull resistors and LEDs on the shared LED pins.
// Assumes the bench picks the wanted pull levels before each reset.
`timescale 1ns/100ps
`default_nettype none
module rsl_strap_board (
  // Wanted strap levels
  input wire logic [4:0] baseWant,
  input wire logic testWant,
  input wire logic [7:0] ledPull,
  // Shared LED pins
  input wire logic [7:0] ledPinOut,
  input wire logic [7:0] ledPinOe,
  output logic [7:0] ledPinIn,
  // Resistor-strapped pins
  output logic [4:0] baseStrap,
  output logic testSelect
);
  // Board never straps a base whose top port passes 0x1f
  assign baseStrap = (baseWant > 5'h1c) ? 5'h1c : baseWant;
  assign testSelect = testWant;
  // A released pin settles to its pull, not its last drive
  assign ledPinIn = (ledPinOe & ledPinOut) | (~ledPinOe & ledPull);
endmodule // rsl_strap_board
`default_nettype wire

// ==== sim/tb_reset_strap_latch.sv ====
// Bench for the strap latch: random straps, reset, port and register checks.
// Assumes one AHB-Lite master and the board model on the strap pins.
`timescale 1ns/100ps
`default_nettype none
module tb_reset_strap_latch;
  logic clk_sys, rst_b, bcast, style, testWant, hsel, hwrite, hreadyout, hresp;
  logic ledStyle, testState, strapsValid, broadcastHit, testSelect;
  logic [4:0] baseWant, baseStrap, mode, mgmtAddr, deviceMode, base;
  logic [7:0] ledPull, ledPinIn, ledPinOut, ledPinOe, ledOutputPolarity;
  logic [3:0] portHit;
  logic [19:0] portAddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  int failCount, checksDone;

  rsl_strap_board board (.baseWant, .testWant, .ledPull, .ledPinOut, .ledPinOe, .ledPinIn,
    .baseStrap, .testSelect);
  rsl_strap_latch dut (.clk_sys, .rst_b, .mgmtBaseAddrStrap(baseStrap), .modeSelStrap(mode),
    .broadcastDefaultStrap(bcast), .ledStyleStrap(style), .testSelect, .ledPinIn, .ledPinOut,
    .ledPinOe, .mgmtAddr, .portHit, .broadcastHit, .portAddr, .deviceMode, .ledStyle,
    .ledOutputPolarity, .testState, .strapsValid, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);

  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function logic [31:0] expStatus();
    expStatus = {1'b1, testWant, 12'h000, style, bcast, 3'h0, mode, 3'h0, base};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Ready is taken at the rising edge, before that edge's own updates land
  // No limit here: only the watchdog ends a wait that never finishes
  task waitReady;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    waitReady;
    htrans <= 2'h0;
    hwdata <= wd;
    waitReady;
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "resp");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (8000) @(posedge clk_sys);
    failCount++;
    complete_run;
  end

  initial begin
    rst_b = 1'b0; {bcast, style, testWant, hsel, hwrite} = 5'h00; baseWant = 5'h00;
    mode = 5'h00; mgmtAddr = 5'h00; ledPull = 8'h00; htrans = 2'h0; hsize = 3'h2;
    haddr = 32'h0000_0000; hwdata = 32'h0000_0000; seed = 32'h0000_004d;
    for (int it = 0; it < 6; it++) begin
      seed = lfsr(seed);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      testWant <= 1'b0;
      baseWant <= (it == 0) ? 5'h1c : (it == 1) ? 5'h00 : seed[4:0];
      ledPull <= (it == 0) ? 8'hff : (it == 1) ? 8'h00 : seed[19:12];
      mode <= seed[9:5];
      bcast <= seed[10];
      style <= seed[11];
      repeat (20) @(posedge clk_sys);
      base = (baseWant > 5'h1c) ? 5'h1c : baseWant;
      rst_b <= 1'b1;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk(strapsValid, 1'b1, "valid");
      chk(deviceMode, mode, "mode");
      chk(ledStyle, style, "style");
      chk(ledOutputPolarity, {~ledPull}, "polarity");
      chk(portAddr, {base + 5'd3, base + 5'd2, base + 5'd1, base}, "port addr");
      chk(ledPinOe, 8'hff, "led oe");
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_sys);
        mgmtAddr <= base + 5'(k);
        @(negedge clk_sys);
        chk(portHit, 4'h1 << k, "port hit");
      end
      @(posedge clk_sys);
      mgmtAddr <= 5'h00;
      @(negedge clk_sys);
      chk(broadcastHit, {~bcast}, "bcast hit");
      @(posedge clk_sys);
      ahb(1'b0, 8'h00, 32'h0);
      chk(rd, expStatus(), "status");
      ahb(1'b0, 8'h04, 32'h0);
      chk(rd, {24'h000000, ~ledPull}, "ledpol reg");
      ahb(1'b0, 8'h0c, 32'h0);
      chk(rd, {3'h0, base + 5'd3, 3'h0, base + 5'd2, 3'h0, base + 5'd1, 3'h0, base}, "pa");
      ahb(1'b0, 8'h08, 32'h0);
      chk(rd, {31'h0, ~bcast}, "ctrl");
      ahb(1'b1, 8'h08, {16'h0000, seed[27:20], 8'h00});
      @(negedge clk_sys);
      chk(ledPinOut, {ledPull ^ seed[27:20]}, "led out");
      @(posedge clk_sys);
      ahb(1'b1, 8'h00, 32'hffff_ffff);
      ahb(1'b0, 8'h00, 32'h0);
      chk(rd, expStatus(), "status ro");
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd, 32'h0, "unmapped");
      mode <= ~mode;
      ledPull <= ~ledPull;
      repeat (3) @(posedge clk_sys);
      testWant <= 1'b1;
      @(negedge clk_sys);
      chk(deviceMode, {~mode}, "mode held");
      chk(ledOutputPolarity, ledPull, "pol held");
      chk({testState, ledPinOe}, 9'h100, "test state");
      $display("test %0d done", it);
    end
    complete_run;
  end
endmodule // tb_reset_strap_latch
`default_nettype wire
